/* rtl/hv_lock_pkg.sv */
// types for the high-voltage lock and protect command handler
package hv_lock_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_WRITING} nv_state_e;
endpackage

/* rtl/hv_lock_protect_command_handler.sv */
// serial command handler for high-voltage lock and protect commands
//
// Summary of operation
// - nonvolatile write starts only after eight command clocks and chip select rising
// - chip select may be reasserted immediately; no gap enforced
// - during a write cycle only addresses 00h, 01h, 04h, 05h are accepted
// - nonvolatile-address commands are ignored without effect until the write ends
// - write-active flag shows a write cycle in progress
// - step commands to 00h or 01h step wiper 0 or wiper 1
// - step command to 04h keeps terminal control and sets command error
// - step commands to 05h..0Eh are invalid and set command error
// - high-voltage decrement sets, increment clears, locks at 02h, 03h, protect 0Fh
// - after command error, serial output stays low until chip select rises
`timescale 1ns/1ps
`default_nettype none
`include "hv_lock_regs.svh"
module hv_lock_protect_command_handler
  import hv_lock_pkg::*;
#(
  parameter int unsigned NV_WRITE_CYCLES = (`NV_WRITE_TIME_NS / `CLK_PERIOD_NS)
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic cs_b_i,
  input wire logic high_voltage_select_level_i,
  input wire logic sck_i,
  input wire logic sdi_i,
  output logic sdo_o,
  output logic sdo_oe_b_o,
  output logic [8:0] wiper0_o,
  output logic [8:0] wiper1_o,
  output logic wiper0_lock_bit_o,
  output logic wiper1_lock_bit_o,
  output logic write_protect_bit_o,
  output logic nv_write_active_flag_o,
  output logic command_error_flag_o
);
  // two-flop synchronisers for pins
  logic [1:0] cs_sync, hv_sync, sck_sync, sdi_sync;
  logic sck_last, cs_last;
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      cs_sync <= 2'b11;
      hv_sync <= 2'b00;
      sck_sync <= 2'b00;
      sdi_sync <= 2'b00;
      sck_last <= 1'b0;
      cs_last <= 1'b1;
    end else begin
      cs_sync <= {cs_sync[0], cs_b_i};
      hv_sync <= {hv_sync[0], high_voltage_select_level_i};
      sck_sync <= {sck_sync[0], sck_i};
      sdi_sync <= {sdi_sync[0], sdi_i};
      sck_last <= sck_sync[1];
      cs_last <= cs_sync[1];
    end
  end

  logic cs_act, sck_rise, sck_fall, cs_rise;
  // high voltage on chip select also counts as active
  assign cs_act = !cs_sync[1] || hv_sync[1];
  assign sck_rise = cs_act && sck_sync[1] && !sck_last;
  assign sck_fall = cs_act && !sck_sync[1] && sck_last;
  assign cs_rise = cs_sync[1] && !cs_last && !hv_sync[1];

  // decode of volatile addresses, used in one place
  function automatic logic is_volatile(input logic [3:0] a);
    is_volatile = (a == `ADDR_WIPER0) || (a == `ADDR_WIPER1) ||
                  (a == `ADDR_TERM_CTRL) || (a == `ADDR_VOL_RSVD);
  endfunction

  function automatic logic is_nv_lock(input logic [3:0] a);
    is_nv_lock = (a == `ADDR_LOCK0) || (a == `ADDR_LOCK1) || (a == `ADDR_PROTECT);
  endfunction

  // shifter, wipers, locks, pending write, error
  logic [7:0] shreg, next_shreg;
  logic [3:0] bitcnt, next_bitcnt;
  logic [8:0] w0, w1, next_w0, next_w1;
  logic lk0, lk1, wp, next_lk0, next_lk1, next_wp;
  logic err, next_err;
  logic sdo, next_sdo;
  logic [3:0] pend_addr, next_pend_addr;
  logic pend_val, next_pend_val;
  nv_state_e state, next_state;
  logic timer_start, timer_busy, timer_done;
  logic [7:0] cmd;
  logic [3:0] addr;
  logic [1:0] op;

  assign cmd = {shreg[6:0], sdi_sync[1]};
  assign addr = cmd[7:4];
  assign op = cmd[3:2];

  always_comb begin
    next_shreg = shreg;
    next_bitcnt = bitcnt;
    next_w0 = w0;
    next_w1 = w1;
    next_lk0 = lk0;
    next_lk1 = lk1;
    next_wp = wp;
    next_err = err;
    next_sdo = sdo;
    next_pend_addr = pend_addr;
    next_pend_val = pend_val;
    next_state = state;
    timer_start = 1'b0;
    if (!cs_act) begin
      next_bitcnt = 4'h0;
      next_err = 1'b0;
      next_sdo = 1'b1;
    end else if (sck_rise) begin
      next_shreg = cmd;
      if (bitcnt == `ERR_BIT_POS) begin
        next_bitcnt = 4'h0;
        // commands to nonvolatile addresses dropped while writing
        if (state == ST_IDLE || is_volatile(addr)) begin
          if (op == `OP_INCR || op == `OP_DECR) begin
            if (addr == `ADDR_WIPER0) begin
              if (op == `OP_INCR && w0 < `WIPER_FULL) next_w0 = w0 + 9'h001;
              if (op == `OP_DECR && w0 > `WIPER_ZERO && w0 <= `WIPER_FULL)
                next_w0 = w0 - 9'h001;
            end else if (addr == `ADDR_WIPER1) begin
              if (op == `OP_INCR && w1 < `WIPER_FULL) next_w1 = w1 + 9'h001;
              if (op == `OP_DECR && w1 > `WIPER_ZERO && w1 <= `WIPER_FULL)
                next_w1 = w1 - 9'h001;
            end else if (is_nv_lock(addr) && hv_sync[1] && state == ST_IDLE) begin
              next_pend_addr = addr;
              next_pend_val = (op == `OP_DECR);
              next_state = ST_ARMED;
            end else begin
              next_err = 1'b1;
            end
          end
        end
      end else begin
        next_bitcnt = bitcnt + 4'h1;
      end
    end else if (sck_fall) begin
      next_sdo = !err;
    end
    // armed write launches on chip select release
    if (state == ST_ARMED && cs_rise) begin
      timer_start = 1'b1;
      next_state = ST_WRITING;
    end
    if (state == ST_WRITING && timer_done) begin
      next_state = ST_IDLE;
      case (pend_addr)
        `ADDR_LOCK0: next_lk0 = pend_val;
        `ADDR_LOCK1: next_lk1 = pend_val;
        `ADDR_PROTECT: next_wp = pend_val;
        default: next_wp = wp;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      shreg <= 8'h00;
      bitcnt <= 4'h0;
      w0 <= `WIPER_RESET;
      w1 <= `WIPER_RESET;
      lk0 <= 1'b0;
      lk1 <= 1'b0;
      wp <= 1'b0;
      err <= 1'b0;
      sdo <= 1'b1;
      pend_addr <= 4'h0;
      pend_val <= 1'b0;
      state <= ST_IDLE;
    end else begin
      shreg <= next_shreg;
      bitcnt <= next_bitcnt;
      w0 <= next_w0;
      w1 <= next_w1;
      lk0 <= next_lk0;
      lk1 <= next_lk1;
      wp <= next_wp;
      err <= next_err;
      sdo <= next_sdo;
      pend_addr <= next_pend_addr;
      pend_val <= next_pend_val;
      state <= next_state;
    end
  end

  nv_write_timer #(.CYCLES(NV_WRITE_CYCLES)) u_timer (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .start_i(timer_start),
    .busy_o(timer_busy),
    .done_o(timer_done)
  );

  // outputs; open-drain data pin drives only a low
  assign sdo_o = 1'b0;
  assign sdo_oe_b_o = sdo;
  assign wiper0_o = w0;
  assign wiper1_o = w1;
  assign wiper0_lock_bit_o = lk0;
  assign wiper1_lock_bit_o = lk1;
  assign write_protect_bit_o = wp;
  assign nv_write_active_flag_o = (state == ST_WRITING);
  assign command_error_flag_o = err;

  // checks
  property p_start_on_release;
    @(posedge clk_i) disable iff (!rst_b_i)
    (state == ST_ARMED && cs_rise) |=> nv_write_active_flag_o;
  endproperty
  a_start_on_release: assert property (p_start_on_release) else $error("write not started");
  property p_flag_tracks_timer;
    @(posedge clk_i) disable iff (!rst_b_i)
    nv_write_active_flag_o == (timer_busy || timer_done);
  endproperty
  a_flag_tracks_timer: assert property (p_flag_tracks_timer) else $error("flag mismatch");
  property p_locks_hold_while_writing;
    @(posedge clk_i) disable iff (!rst_b_i)
    (nv_write_active_flag_o && !timer_done) |=> $stable(wp) && $stable(lk0) && $stable(lk1);
  endproperty
  a_locks_hold_while_writing: assert property (p_locks_hold_while_writing) else $error("lock changed");
  property p_err_low_out;
    @(posedge clk_i) disable iff (!rst_b_i)
    (err && sck_fall) |=> sdo_oe_b_o == 1'b0;
  endproperty
  a_err_low_out: assert property (p_err_low_out) else $error("output not low on error");
  property p_err_cleared;
    @(posedge clk_i) disable iff (!rst_b_i)
    !cs_act |=> !err;
  endproperty
  a_err_cleared: assert property (p_err_cleared) else $error("error not cleared");
  property p_wiper_bounds;
    @(posedge clk_i) disable iff (!rst_b_i)
    $changed(w0) |-> (w0 <= `WIPER_FULL) && ($past(w0) - w0 == 9'h001 || w0 - $past(w0) == 9'h001);
  endproperty
  a_wiper_bounds: assert property (p_wiper_bounds) else $error("bad wiper step");
  property p_armed_needs_hv;
    @(posedge clk_i) disable iff (!rst_b_i)
    (state == ST_IDLE && next_state == ST_ARMED) |-> hv_sync[1];
  endproperty
  a_armed_needs_hv: assert property (p_armed_needs_hv) else $error("armed without high voltage");
  property p_term_ctrl_err;
    @(posedge clk_i) disable iff (!rst_b_i)
    (sck_rise && bitcnt == `ERR_BIT_POS && addr == `ADDR_TERM_CTRL && op == `OP_INCR) |=> err;
  endproperty
  a_term_ctrl_err: assert property (p_term_ctrl_err) else $error("no error at 04h");
endmodule
`default_nettype wire

/* rtl/hv_lock_regs.svh */
// constants for the high-voltage lock and protect command handler
`ifndef HV_LOCK_REGS_SVH
`define HV_LOCK_REGS_SVH
`define ADDR_WIPER0 4'h0
`define ADDR_WIPER1 4'h1
`define ADDR_LOCK0 4'h2
`define ADDR_LOCK1 4'h3
`define ADDR_TERM_CTRL 4'h4
`define ADDR_VOL_RSVD 4'h5
`define ADDR_PROTECT 4'hf
`define OP_INCR 2'h1
`define OP_DECR 2'h2
`define WIPER_FULL 9'h100
`define WIPER_ZERO 9'h000
`define WIPER_RESET 9'h080
`define CMD_BITS 4'h8
`define ERR_BIT_POS 4'h7
`define NV_WRITE_TIME_NS 5000000
`define CLK_PERIOD_NS 8
`endif

/* rtl/nv_write_timer.sv */
// write cycle timer: counts the nonvolatile write cycle time
`timescale 1ns/1ps
`default_nettype none
module nv_write_timer #(
  parameter int unsigned CYCLES = 625000
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic start_i,
  output logic busy_o,
  output logic done_o
);
  logic [31:0] count;
  logic [31:0] next_count;
  logic busy;
  logic next_busy;
  logic done;
  logic next_done;

  // counter next state
  always_comb begin
    next_count = count;
    next_busy = busy;
    next_done = 1'b0;
    if (start_i && !busy) begin
      next_count = CYCLES - 32'd1;
      next_busy = 1'b1;
    end else if (busy) begin
      if (count == 32'd0) begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end else begin
        next_count = count - 32'd1;
      end
    end
  end

  // counter registers
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      count <= 32'd0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      count <= next_count;
      busy <= next_busy;
      done <= next_done;
    end
  end

  assign busy_o = busy;
  assign done_o = done;
endmodule
`default_nettype wire

/* tb/hv_lock_protect_command_handler_tb.sv */
// self-checking bench for the high-voltage lock and protect command handler
`timescale 1ns/1ps
`default_nettype none
`include "hv_lock_regs.svh"
module hv_lock_protect_command_handler_tb;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  wire logic cs_b, hv, sck, sdi;
  logic sdo, oe_b, lk0, lk1, wp, act, err;
  logic [8:0] w0, w1, e0, e1;
  logic [2:0] el;
  logic [1:0] op;
  logic [3:0] a;
  logic [3:0] nv_addr [3] = '{`ADDR_LOCK0, `ADDR_LOCK1, `ADDR_PROTECT};
  int mismatches = 0;
  int tests_run = 0;
  // 125 MHz clock
  always #4 clk_i = ~clk_i;
  spi_host_model host (.clk_i(clk_i), .cs_b_o(cs_b), .hv_o(hv), .sck_o(sck), .sdi_o(sdi));
  hv_lock_protect_command_handler #(.NV_WRITE_CYCLES(1000)) uut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .cs_b_i(cs_b), .high_voltage_select_level_i(hv),
    .sck_i(sck), .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_b_o(oe_b), .wiper0_o(w0), .wiper1_o(w1),
    .wiper0_lock_bit_o(lk0), .wiper1_lock_bit_o(lk1), .write_protect_bit_o(wp),
    .nv_write_active_flag_o(act), .command_error_flag_o(err));
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [8:0] exp, input logic [8:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // bounded wait on the write-active flag
  task automatic wait_act(input logic want);
    int n;
    n = 0;
    while (act !== want && n < 3000) begin
      @(negedge clk_i);
      n++;
    end
    if (act !== want) begin
      mismatches++;
      $display("ERROR nv_write_active expected %b seen %b", want, act);
      final_report();
    end
  endtask
  // expected wiper after one step, saturating at both ends
  function automatic logic [8:0] step(input logic [8:0] w, input logic [1:0] o);
    if (o == `OP_INCR) begin
      return (w < `WIPER_FULL) ? w + 9'h001 : w;
    end
    return (w == `WIPER_ZERO || w > `WIPER_FULL) ? w : w - 9'h001;
  endfunction
  function automatic logic [7:0] cmd(input logic [3:0] ad, input logic [1:0] o);
    return {ad, o, 2'h0};
  endfunction
  // high-voltage command in its own frame; write starts after select rises
  task automatic nv_cmd(input logic [3:0] ad, input logic [1:0] o);
    host.frame_open(1'b1);
    host.send_byte(cmd(ad, o));
    check("act_in_frame", 9'h000, {8'h00, act});
    host.frame_close();
    wait_act(1'b1);
  endtask
  task automatic both_wipers();
    check("wiper0", e0, w0);
    check("wiper1", e1, w1);
  endtask
  // main sequence
  initial begin
    void'($urandom(49));
    e0 = `WIPER_RESET;
    e1 = `WIPER_RESET;
    el = 3'h0;
    repeat (16) @(negedge clk_i);
    rst_b_i = 1'b1;
    repeat (4) @(negedge clk_i);
    both_wipers();
    check("locks", 9'h000, {6'h00, wp, lk1, lk0});
    check("flags", 9'h001, {6'h00, act, err, oe_b});
    $display("test reset done");
    nv_cmd(`ADDR_LOCK0, `OP_DECR);
    host.frame_open(1'b1);
    host.send_byte(cmd(`ADDR_LOCK1, `OP_DECR));
    check("err_busy", 9'h000, {8'h00, err});
    for (int i = 0; i < 2; i++) begin
      op = i ? `OP_DECR : `OP_INCR;
      a = i ? `ADDR_WIPER1 : `ADDR_WIPER0;
      host.send_byte(cmd(a, op));
      if (i) e1 = step(e1, op);
      else e0 = step(e0, op);
      both_wipers();
    end
    check("act_busy", 9'h001, {8'h00, act});
    host.frame_close();
    wait_act(1'b0);
    el = 3'h1;
    check("locks", {6'h00, el}, {6'h00, wp, lk1, lk0});
    $display("test busy done");
    for (int i = 0; i < 6; i++) begin
      op = (i < 3) ? `OP_DECR : `OP_INCR;
      nv_cmd(nv_addr[i % 3], op);
      wait_act(1'b0);
      el[i % 3] = (op == `OP_DECR);
      check("locks", {6'h00, el}, {6'h00, wp, lk1, lk0});
    end
    $display("test locks done");
    for (int i = 4; i < 15; i++) begin
      op = ($urandom % 2) ? `OP_INCR : `OP_DECR;
      host.frame_open($urandom % 2 == 1);
      host.send_byte(cmd(i[3:0], op));
      check("err_set", 9'h001, {8'h00, err});
      host.send_byte(8'h00);
      repeat (4) @(negedge clk_i);
      check("sdo_err", 9'h000, {7'h00, sdo, oe_b});
      host.frame_close();
      repeat (6) @(negedge clk_i);
      check("after", {6'h00, el}, {4'h0, err, act, wp, lk1, lk0});
      both_wipers();
    end
    $display("test errors done");
    host.frame_open(1'b0);
    for (int i = 0; i < 400; i++) begin
      op = (i < 40) ? (($urandom % 2) ? `OP_INCR : `OP_DECR) : (i % 2 ? `OP_DECR : `OP_INCR);
      a = (i < 40) ? (($urandom % 2) ? `ADDR_WIPER1 : `ADDR_WIPER0) : (i % 2 ? 4'h1 : 4'h0);
      host.send_byte(cmd(a, op));
      if (a == `ADDR_WIPER1) e1 = step(e1, op);
      else e0 = step(e0, op);
      if (i < 40 || i == 399) both_wipers();
    end
    host.frame_close();
    $display("test steps done");
    final_report();
  end
endmodule
`default_nettype wire

/* tb/spi_host_model.sv */
// host serial master model driving the command handler pins
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  input wire logic clk_i,
  output logic cs_b_o,
  output logic hv_o,
  output logic sck_o,
  output logic sdi_o
);
  // idle pins: select high, serial clock parked low
  initial begin
    cs_b_o = 1'b1;
    hv_o = 1'b0;
    sck_o = 1'b0;
    sdi_o = 1'b1;
  end
  // one command byte, msb first, 160 ns serial clock
  task automatic send_byte(input logic [7:0] cmd);
    for (int i = 7; i >= 0; i--) begin
      sdi_o = cmd[i];
      repeat (10) @(negedge clk_i);
      sck_o = 1'b1;
      repeat (10) @(negedge clk_i);
      sck_o = 1'b0;
    end
    sdi_o = ~cmd[0]; // stale data line shows the inverse
  endtask
  // select goes active, with or without high voltage
  task automatic frame_open(input logic hv);
    @(negedge clk_i);
    cs_b_o = 1'b0;
    hv_o = hv;
    repeat (4) @(negedge clk_i);
  endtask
  // select goes inactive; a new frame may follow at once
  task automatic frame_close();
    @(negedge clk_i);
    hv_o = 1'b0;
    cs_b_o = 1'b1;
    @(negedge clk_i);
  endtask
endmodule
`default_nettype wire
